// *** hdl/mcd_pkg.sv ***
/*
 * Constants and types of the motion change detector, second configuration stage.
 * Assumes one 10 MHz clock and an asynchronous active-low reset in every user.
 */
`default_nettype none

package mcd_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] CFG2_ADDR        = 8'h30;
   localparam logic [7:0] CFG2_RST_GND     = 8'h00;   // Boot pin grounded
   localparam logic [7:0] CFG2_RST_VDD     = 8'hd8;   // Boot pin high, motion selected
   localparam logic [7:0] CFG2_RST_VDD_NOM = 8'h58;   // Boot pin high, no motion select

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int BIT_ENABLE      = 7;
   localparam int BIT_POLICY_HI   = 6;
   localparam int BIT_POLICY_LO   = 5;
   localparam int BIT_OUT_STYLE   = 4;
   localparam int BIT_WIN_STYLE   = 3;
   localparam int BIT_WIN_COMBINE = 2;
   localparam int BIT_MAGNITUDE   = 1;
   localparam int BIT_RELOAD      = 0;

   // ---------------------------------------------------------------
   // Reference policy codes and timing
   // ---------------------------------------------------------------
   localparam logic [1:0] POLICY_FIRST    = 2'h0;
   localparam logic [1:0] POLICY_HOLD     = 2'h1;
   localparam logic [1:0] POLICY_SLOPE    = 2'h2;
   localparam logic [1:0] POLICY_ABSOLUTE = 2'h3;
   localparam logic [1:0] BOOT_WAIT       = 2'h2;     // Cycles for strap sync to settle
   localparam logic [2:0] AXIS_X_ONLY     = 3'h4;     // Axis mask in magnitude mode

   // Three axes of 12-bit data; x in the top field
   typedef struct packed {
      logic [11:0] x;
      logic [11:0] y;
      logic [11:0] z;
   } mcd_axes_t;

endpackage : mcd_pkg

`default_nettype wire

// *** hdl/mcd_debounce.sv ***
/*
 * One debounce counter of the change detector, stepped once per output period.
 * Assumes evalPulse is a one-cycle strobe on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module mcd_debounce
   import mcd_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Control
   input  wire logic       evalPulse,
   input  wire logic       clearCnt,
   input  wire logic       condition,
   input  wire logic       styleClear,
   input  wire logic [7:0] threshold,
   // Status
   output logic      [7:0] count,
   output logic            eventActive
);

   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;
   logic       act_ff;
   logic       nxt_act;

   // ---------------------------------------------------------------
   // Counter step
   // ---------------------------------------------------------------
   // Count up while true, saturating at threshold so decrement-style release takes threshold+1
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_act = act_ff;
      if (clearCnt) begin
         nxt_cnt = 8'h00;
         nxt_act = 1'b0;
      end else if (evalPulse) begin
         if (condition) begin
            if (cnt_ff < threshold) begin
               nxt_cnt = cnt_ff + 8'h01;
            end
            nxt_act = (nxt_cnt >= threshold) | act_ff;
         end else if (styleClear) begin
            nxt_cnt = 8'h00;
            nxt_act = 1'b0;
         end else if (cnt_ff != 8'h00) begin
            nxt_cnt = cnt_ff - 8'h01;
         end else begin
            nxt_act = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 8'h00;
         act_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         act_ff <= nxt_act;
      end
   end

   assign count       = cnt_ff;
   assign eventActive = act_ff;

endmodule // mcd_debounce

`default_nettype wire

// *** hdl/mcd_config.sv ***
/*
 * Second configuration stage of the motion change detector: enable gate,
 * reference policy, debounce control and the axis combine of the results.
 * Assumes threshold comparators, axis enables and count registers outside;
 * sampleValid strobes once per output period with a fresh decimated sample.
 */
// Contract
// - Enable clear gates detector clocks and power
// - Enable set initialises references per policy
// - Enable reset default follows boot pin; the code sets enable only if motionDetectSelect is also high
// - Fixed layout of the configuration fields
// - Policy 00 reloads reference on outside event
// - Policy 01 holds reference until reload
// - Policy 10 reloads reference every period
// - Policy 11 forces zero references
// - Outside decrement style counts down when false
// - Outside release needs count plus one periods
// - Outside clear style zeroes counter when false
// - Within decrement style counts down when false
// - Within release needs count plus one periods
// - Within clear style zeroes counter when false
// - Bit 2 picks AND or OR combine
// - Magnitude mode uses X channel only
// - Reload request self-clears, skipped in absolute
`timescale 1ns/1ps
`default_nettype none

module mcd_config
   import mcd_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Register port
   input  wire logic       regWrite,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   output logic      [7:0] regRdData,
   // Straps and soft reset
   input  wire logic       bootModePin,
   input  wire logic       motionDetectSelect,
   input  wire logic       softReset,
   // Sample stream and comparator results
   input  wire logic       sampleValid,
   input  wire mcd_axes_t  sampleData,
   input  wire logic [2:0] outsideResult,
   input  wire logic [2:0] withinResult,
   input  wire logic [2:0] outsideAxisEnable,
   input  wire logic [2:0] withinAxisEnable,
   input  wire logic [7:0] outsideThreshold,
   input  wire logic [7:0] withinThreshold,
   // Detector state
   output mcd_axes_t       reference,
   output logic            detectorPowerOn,
   output logic            outsideEventActive,
   output logic            withinEventActive,
   output logic      [7:0] outsideDebounceCount,
   output logic      [7:0] withinDebounceCount
);

   // ---------------------------------------------------------------
   // Boot strap capture
   // ---------------------------------------------------------------
   logic       bootMeta_ff;
   logic       bootSync_ff;
   logic [1:0] bootCnt_ff;
   logic [1:0] nxt_bootCnt;
   logic       bootLoad;

   // Strap is a pin: two flops before use
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bootMeta_ff <= 1'b0;
         bootSync_ff <= 1'b0;
      end else begin
         bootMeta_ff <= bootModePin;
         bootSync_ff <= bootMeta_ff;
      end
   end

   // Wait out the synchroniser, then load defaults once; soft reset restarts
   always_comb begin
      nxt_bootCnt = bootCnt_ff;
      if (softReset) begin
         nxt_bootCnt = 2'h0;
      end else if (bootCnt_ff <= BOOT_WAIT) begin
         nxt_bootCnt = bootCnt_ff + 2'h1;
      end
   end
   assign bootLoad = (bootCnt_ff == BOOT_WAIT) & ~softReset;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bootCnt_ff <= 2'h0;
      end else begin
         bootCnt_ff <= nxt_bootCnt;
      end
   end

   // ---------------------------------------------------------------
   // Configuration register
   // ---------------------------------------------------------------
   logic [7:0] cfg_ff;
   logic [7:0] nxt_cfg;
   logic       enabled;
   logic [1:0] policy;
   logic       evalPulse;
   logic       reloadDone;
   logic       cfgHit;

   assign enabled   = cfg_ff[BIT_ENABLE];
   assign policy    = cfg_ff[BIT_POLICY_HI:BIT_POLICY_LO];
   assign evalPulse = sampleValid & enabled;
   assign cfgHit    = regWrite & (regAddr == CFG2_ADDR);

   // Write wins over the reload self-clear whatever its reload bit, so a new request is never lost
   always_comb begin
      nxt_cfg = cfg_ff;
      if (softReset) begin
         nxt_cfg = CFG2_RST_GND;
      end else if (bootLoad) begin
         if (!bootSync_ff) begin
            nxt_cfg = CFG2_RST_GND;
         end else if (motionDetectSelect) begin
            nxt_cfg = CFG2_RST_VDD;
         end else begin
            nxt_cfg = CFG2_RST_VDD_NOM;
         end
      end else begin
         if (reloadDone) begin
            nxt_cfg[BIT_RELOAD] = 1'b0;
         end
         if (cfgHit) begin
            nxt_cfg = regWrData;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ff <= CFG2_RST_GND;
      end else begin
         cfg_ff <= nxt_cfg;
      end
   end
   // Unmapped addresses read as zero
   always_comb begin
      if (regAddr == CFG2_ADDR) begin
         regRdData = cfg_ff;
      end else begin
         regRdData = 8'h00;
      end
   end

   // Clock and power gate of the detector
   assign detectorPowerOn = enabled;

   // ---------------------------------------------------------------
   // Axis combine
   // ---------------------------------------------------------------
   logic [2:0] outMask;
   logic [2:0] winMask;
   logic       outsideCond;
   logic       withinCond;

   // Magnitude lives on the X channel alone
   always_comb begin
      outMask = outsideAxisEnable;
      winMask = withinAxisEnable;
      if (cfg_ff[BIT_MAGNITUDE]) begin
         outMask = outsideAxisEnable & AXIS_X_ONLY;
         winMask = withinAxisEnable & AXIS_X_ONLY;
      end
      outsideCond = |(outsideResult & outMask);
      if (cfg_ff[BIT_WIN_COMBINE]) begin
         withinCond = |(withinResult & winMask);
      end else begin
         withinCond = (winMask != 3'h0) & (&(withinResult | ~winMask));
      end
   end

   // ---------------------------------------------------------------
   // Debounce counters
   // ---------------------------------------------------------------
   logic enRise;
   logic prevEn_ff;
   assign enRise = enabled & ~prevEn_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prevEn_ff <= 1'b0;
      end else begin
         prevEn_ff <= enabled;
      end
   end

   mcd_debounce outsideDebounce (
      .clk         (clk),
      .rst_n       (rst_n),
      .evalPulse   (evalPulse),
      .clearCnt    (enRise),
      .condition   (outsideCond),
      .styleClear  (cfg_ff[BIT_OUT_STYLE]),
      .threshold   (outsideThreshold),
      .count       (outsideDebounceCount),
      .eventActive (outsideEventActive)
   );
   mcd_debounce withinDebounce (
      .clk         (clk),
      .rst_n       (rst_n),
      .evalPulse   (evalPulse),
      .clearCnt    (enRise),
      .condition   (withinCond),
      .styleClear  (cfg_ff[BIT_WIN_STYLE]),
      .threshold   (withinThreshold),
      .count       (withinDebounceCount),
      .eventActive (withinEventActive)
   );

   // ---------------------------------------------------------------
   // Reference values
   // ---------------------------------------------------------------
   mcd_axes_t ref_ff;
   mcd_axes_t nxt_ref;
   logic      firstPending_ff;
   logic      nxt_firstPending;
   // Updates land after the period's evaluation, so slope mode sees n minus n-1
   always_comb begin
      nxt_ref          = ref_ff;
      nxt_firstPending = firstPending_ff;
      reloadDone       = 1'b0;
      if (enRise) begin
         nxt_firstPending = 1'b1;
      end
      if (enabled && policy == POLICY_ABSOLUTE) begin
         nxt_ref          = '0;
         nxt_firstPending = 1'b0;
         reloadDone       = cfg_ff[BIT_RELOAD] & sampleValid;
      end else if (evalPulse) begin
         if (firstPending_ff || enRise || cfg_ff[BIT_RELOAD]) begin
            nxt_ref          = sampleData;
            nxt_firstPending = 1'b0;
            reloadDone       = cfg_ff[BIT_RELOAD];
         end else if (policy == POLICY_SLOPE) begin
            nxt_ref = sampleData;
         end else if (policy == POLICY_FIRST && outsideEventActive) begin
            nxt_ref = sampleData;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_ff          <= '0;
         firstPending_ff <= 1'b0;
      end else begin
         ref_ff          <= nxt_ref;
         firstPending_ff <= nxt_firstPending;
      end
   end
   assign reference = ref_ff;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   power_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
      !cfg_ff[BIT_ENABLE] |-> (!detectorPowerOn && !evalPulse))
      else $error("detector powered while disabled");
   first_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
      (firstPending_ff && evalPulse && policy != POLICY_ABSOLUTE && !enRise) |=> (reference == $past(sampleData)))
      else $error("first sample not captured");
   boot_default_a: assert property (@(posedge clk) disable iff (!rst_n)
      (bootLoad && !softReset && !bootSync_ff) |=> (cfg_ff == CFG2_RST_GND))
      else $error("boot default wrong");
   hold_ref_a: assert property (@(posedge clk) disable iff (!rst_n)
      (policy == POLICY_HOLD && !firstPending_ff && !cfg_ff[BIT_RELOAD] && !enRise && !softReset && !bootLoad
       && !cfgHit) |=> $stable(reference))
      else $error("held reference moved");
   slope_ref_a: assert property (@(posedge clk) disable iff (!rst_n)
      (evalPulse && policy == POLICY_SLOPE) |=> (reference == $past(sampleData)))
      else $error("slope reference not refreshed");
   absolute_ref_a: assert property (@(posedge clk) disable iff (!rst_n)
      (enabled && policy == POLICY_ABSOLUTE) |=> (reference == '0))
      else $error("absolute reference not zero");
   reload_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      (cfg_ff[BIT_RELOAD] && evalPulse && !cfgHit && !softReset && !bootLoad) |=> !cfg_ff[BIT_RELOAD])
      else $error("reload request did not self-clear");
   disabled_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!enabled && !prevEn_ff) |=> $stable(outsideDebounceCount) && $stable(withinDebounceCount))
      else $error("counters moved while disabled");
   magnitude_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_ff[BIT_MAGNITUDE] |-> (outMask[1:0] == 2'h0) && (winMask[1:0] == 2'h0))
      else $error("non-X axis used in magnitude mode");

endmodule // mcd_config

`default_nettype wire

// *** test/tb_top.sv ***
/*
 * Self-checking bench of mcd_config: register port, straps, sample stream.
 * Assumes mcd_pkg and mcd_config are compiled first; assertions live in hdl.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top
   import mcd_pkg::*;
;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic       clk                = 1'b0;
   logic       rst_n              = 1'b0;
   logic       regWrite           = 1'b0;
   logic [7:0] regAddr            = 8'h30;
   logic [7:0] regWrData          = 8'h00;
   logic [7:0] regRdData;
   logic       bootModePin        = 1'b0;
   logic       motionDetectSelect = 1'b0;
   logic       softReset          = 1'b0;
   logic       sampleValid        = 1'b0;
   mcd_axes_t  sampleData         = '0;
   mcd_axes_t  reference;
   logic [2:0] outsideResult      = 3'h0;
   logic [2:0] withinResult       = 3'h0;
   logic [2:0] outsideAxisEnable  = 3'h7;
   logic [2:0] withinAxisEnable   = 3'h7;
   logic [7:0] outsideThreshold   = 8'h02;
   logic [7:0] withinThreshold    = 8'h01;
   logic       detectorPowerOn;
   logic       outsideEventActive;
   logic       withinEventActive;
   logic [7:0] outsideDebounceCount;
   logic [7:0] withinDebounceCount;
   int         n_errors           = 0;
   int         samples_checked    = 0;
   int         cycles             = 0;

   mcd_config u_mcd_config (
      .clk(clk), .rst_n(rst_n),
      .regWrite(regWrite), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
      .bootModePin(bootModePin), .motionDetectSelect(motionDetectSelect), .softReset(softReset),
      .sampleValid(sampleValid), .sampleData(sampleData),
      .outsideResult(outsideResult), .withinResult(withinResult),
      .outsideAxisEnable(outsideAxisEnable), .withinAxisEnable(withinAxisEnable),
      .outsideThreshold(outsideThreshold), .withinThreshold(withinThreshold),
      .reference(reference), .detectorPowerOn(detectorPowerOn),
      .outsideEventActive(outsideEventActive), .withinEventActive(withinEventActive),
      .outsideDebounceCount(outsideDebounceCount), .withinDebounceCount(withinDebounceCount)
   );

   // ---------------------------------------------------------------
   // Clock and hang guard
   // ---------------------------------------------------------------
   always #50 clk = ~clk;

   // Whole run is about 150 cycles; the ceiling leaves ample room
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         results();
      end
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic results();
      $display("Checks %0d, errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One write cycle; address returns to the config byte so reads see it
   task automatic wr(input logic [7:0] addr, input logic [7:0] d);
      @(posedge clk);
      regWrite  <= 1'b1;
      regAddr   <= addr;
      regWrData <= d;
      @(posedge clk);
      regWrite  <= 1'b0;
      regAddr   <= CFG2_ADDR;
      #1;
   endtask

   // One output period: strobe a sample with its comparator results
   task automatic samp(input mcd_axes_t d, input logic [2:0] o, input logic [2:0] w);
      @(posedge clk);
      sampleValid   <= 1'b1;
      sampleData    <= d;
      outsideResult <= o;
      withinResult  <= w;
      @(posedge clk);
      sampleValid   <= 1'b0;
      #1;
   endtask

   function automatic mcd_axes_t dat(input logic [3:0] k);
      return {k, 8'h1a, k, 8'h2b, k, 8'h3c};
   endfunction

   // One period, then judge both debounce counters and flags
   task automatic step(input logic [2:0] o, w, input logic [7:0] oc, wc, input logic of, wf);
      samp(dat(4'h9), o, w);
      check("outsideCount", outsideDebounceCount, oc);
      check("outsideFlag", outsideEventActive, of);
      check("withinCount", withinDebounceCount, wc);
      check("withinFlag", withinEventActive, wf);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   // Strap defaults through soft reset; grounded strap comes last
   task automatic t_reset();
      logic [1:0] strap [3] = '{2'h3, 2'h2, 2'h0};
      logic [7:0] expv  [3] = '{CFG2_RST_VDD, CFG2_RST_VDD_NOM, CFG2_RST_GND};
      check("resetCfg", regRdData, 8'h00);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         bootModePin        <= strap[i][1];
         motionDetectSelect <= strap[i][0];
         softReset          <= 1'b1;
         @(posedge clk);
         softReset          <= 1'b0;
         repeat (6) @(posedge clk);
         #1;
         check("strapCfg", regRdData, expv[i]);
         check("power", detectorPowerOn, expv[i][7]);
      end
   endtask

   // Field layout and an unmapped address
   task automatic t_layout();
      wr(8'h30, 8'h7e);
      check("layout", regRdData, 8'h7e);
      check("powerOff", detectorPowerOn, 1'b0);
      wr(8'h31, 8'hff);
      check("unmappedWr", regRdData, 8'h7e);
      @(posedge clk);
      regAddr <= 8'h31;
      @(posedge clk);
      #1;
      check("unmappedRd", regRdData, 8'h00);
      @(posedge clk);
      regAddr <= CFG2_ADDR;
   endtask

   // Hold policy, reload request, disable gate and re-enable
   task automatic t_hold();
      wr(8'h30, 8'h00);
      wr(8'h30, 8'ha0);
      samp(dat(4'h1), 3'h0, 3'h0);
      check("firstRef", reference, dat(4'h1));
      samp(dat(4'h2), 3'h0, 3'h0);
      check("heldRef", reference, dat(4'h1));
      wr(8'h30, 8'ha1);
      check("reloadSet", regRdData, 8'ha1);
      samp(dat(4'h3), 3'h0, 3'h0);
      check("reloadRef", reference, dat(4'h3));
      check("reloadClr", regRdData, 8'ha0);
      wr(8'h30, 8'h20);
      check("gateOff", detectorPowerOn, 1'b0);
      samp(dat(4'h4), 3'h0, 3'h0);
      check("idleRef", reference, dat(4'h3));
      wr(8'h30, 8'ha0);
      samp(dat(4'h5), 3'h0, 3'h0);
      check("reEnRef", reference, dat(4'h5));
   endtask

   // Slope tracking, then absolute zero with a skipped reload
   task automatic t_slope_abs();
      wr(8'h30, 8'h00);
      wr(8'h30, 8'hc0);
      for (int k = 6; k < 9; k++) begin
         samp(dat(k[3:0]), 3'h0, 3'h0);
         check("slopeRef", reference, dat(k[3:0]));
      end
      wr(8'h30, 8'h00);
      wr(8'h30, 8'he1);
      samp(dat(4'ha), 3'h0, 3'h0);
      check("absRef", reference, 36'h0);
      check("absClr", regRdData, 8'he0);
   endtask

   // Outside counter: decrement style, clear style, then magnitude mode
   task automatic t_outside();
      logic [8:0] tr      = 9'h1c6;
      logic [8:0] fl      = 9'h0f2;
      logic [7:0] cnt [9] = '{8'h01, 8'h02, 8'h02, 8'h01, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00};
      wr(8'h30, 8'h00);
      wr(8'h30, 8'h80);
      for (int i = 0; i < 9; i++) begin
         if (i == 6) begin
            wr(8'h30, 8'h90);
         end
         step({3{tr[8-i]}}, 3'h0, cnt[i], 8'h00, fl[8-i], 1'b0);
      end
      wr(8'h30, 8'h92);
      step(3'h3, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0);
      step(3'h4, 3'h0, 8'h01, 8'h00, 1'b0, 1'b0);
   endtask

   // Within counter: AND versus OR, two-period release, clear style
   task automatic t_within();
      wr(8'h30, 8'h00);
      wr(8'h30, 8'h80);
      step(3'h0, 3'h4, 8'h00, 8'h00, 1'b0, 1'b0);
      wr(8'h30, 8'h84);
      step(3'h0, 3'h4, 8'h00, 8'h01, 1'b0, 1'b1);
      step(3'h0, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1);
      step(3'h0, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0);
      wr(8'h30, 8'h8c);
      step(3'h0, 3'h4, 8'h00, 8'h01, 1'b0, 1'b1);
      step(3'h0, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0);
   endtask

   // First-sample policy; reload follows the registered outside flag
   task automatic t_first();
      @(posedge clk);
      outsideThreshold <= 8'h00;
      wr(8'h30, 8'h00);
      wr(8'h30, 8'h90);
      samp(dat(4'hb), 3'h0, 3'h0);
      check("firstRef0", reference, dat(4'hb));
      samp(dat(4'hc), 3'h7, 3'h0);
      check("preEvtRef", reference, dat(4'hb));
      samp(dat(4'hd), 3'h7, 3'h0);
      check("evtRef", reference, dat(4'hd));
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      t_reset();
      t_layout();
      t_hold();
      t_slope_abs();
      t_outside();
      t_within();
      t_first();
      results();
   end

endmodule // tb_top

`default_nettype wire
